// file: core/blcr_cfg.svh
// Register offsets, field positions, reset values and timing for the load current readout.
// Assumes a register port with an 8-bit address and 8-bit data from the serial control front end.
`ifndef BLCR_CFG_SVH
`define BLCR_CFG_SVH

`define BLCR_ADDR_SELECT     8'h24
`define BLCR_ADDR_HIGH       8'h25
`define BLCR_ADDR_LOW        8'h26
`define BLCR_SEL_BIT         0
`define BLCR_SELECT_RESET    8'h00
`define BLCR_RESULT_RESET    9'h000
`define BLCR_RESULT_MSB      8
`define BLCR_STEP_MA         20
`define BLCR_FULL_SCALE_MA   10220
`define BLCR_CONV_TIME_NS    1000
`define BLCR_CLK_PERIOD_NS   50
`define BLCR_CONV_CYCLES     ((`BLCR_CONV_TIME_NS + `BLCR_CLK_PERIOD_NS - 1) / `BLCR_CLK_PERIOD_NS)

`endif

// file: core/blcr_pkg.sv
// Types shared by the load current readout files.
// Assumes the constants header is included by the design files.
package blcr_pkg;

  typedef struct packed
  {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } blcr_reg_req_type;

  typedef enum logic [1:0]
  {
    BLCR_IDLE = 2'b01,
    BLCR_CONV = 2'b10
  } blcr_state_type;

endpackage

// file: core/blcr_regs.sv
// Small register store for the select byte and the 9-bit held result.
// Assumes the top drives clean same-clock write strobes.
`timescale 1ns/1ps
`default_nettype none
`include "blcr_cfg.svh"

module blcr_regs
(
  input  wire logic       ref_clk,   // System clock
  input  wire logic       rst_n,     // Synchronised reset
  input  wire logic       sel_we,    // Select register write
  input  wire logic [7:0] sel_wdata, // Select write data
  input  wire logic       res_we,    // Result update strobe
  input  wire logic [8:0] res_wdata, // Finished result
  output var  logic [7:0] sel_q,     // Stored select byte
  output var  logic [8:0] res_q      // Stored result
);

  logic [7:0] next_sel_q;
  logic [8:0] next_res_q;

  always_comb
  begin
    next_sel_q = sel_we ? sel_wdata : sel_q; // see R2 see R6
    next_res_q = res_we ? res_wdata : res_q; // see R7
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_q <= `BLCR_SELECT_RESET;
      res_q <= `BLCR_RESULT_RESET;
    end
    else
    begin
      sel_q <= next_sel_q;
      res_q <= next_res_q;
    end
  end

endmodule
`default_nettype wire

// file: core/blcr_top.sv
// Load current readout: select register starts a measurement, result read back in two bytes.
// Assumes a serial control front end giving one-cycle read/write strobes on ref_clk,
// and an analog sense path giving per-regulator 9-bit averages from another domain.
//
// Notes on behaviour
// R1: Any write to the select register starts a new measurement.
// R2: Select bit 0 picks first (0) or second (1) regulator; resets to 0.
// R3: Result bit 8 reads in high register bit 0, read-only, reset 0.
// R4: Result bits 7..0 read in low register, read-only.
// R5: Result is unsigned count of 20 mA steps, at most 10.22 A.
// R6: Bits 7..1 of select and high register reserved, reset zero.
// R7: Result holds last finished measurement until the next one completes.
`timescale 1ns/1ps
`default_nettype none
`include "blcr_cfg.svh"

module blcr_top
#(
  parameter int CONV_CYCLES = `BLCR_CONV_CYCLES
)
(
  input  wire logic                      ref_clk,       // 20 MHz system clock
  input  wire logic                      arst_n,        // Async reset, active low
  input  wire blcr_pkg::blcr_reg_req_type reg_req,      // Register access request
  input  wire logic [8:0]                sense_first,   // Average of first regulator, async
  input  wire logic [8:0]                sense_second,  // Average of second regulator, async
  output var  logic [7:0]                reg_rdata,     // Read data, valid cycle after rd_en
  output var  logic                      reg_rvalid,    // Read data strobe
  output var  logic                      meas_busy,     // Measurement in progress
  output var  logic                      meas_regulator // Regulator being measured
);

  logic       rst_m;
  logic       rst_n;
  logic [7:0] sel_q;
  logic [8:0] res_q;
  logic [8:0] s1_a;
  logic [8:0] s2_a;
  logic [8:0] s3_a;
  logic [8:0] s1_b;
  logic [8:0] s2_b;
  logic [8:0] s3_b;
  logic [8:0] first_v;
  logic [8:0] second_v;
  logic [8:0] next_first_v;
  logic [8:0] next_second_v;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  // Three-stage capture; a value counts once stages two and three agree
  always_comb
  begin
    next_first_v  = (s2_a == s3_a) ? s3_a : first_v;
    next_second_v = (s2_b == s3_b) ? s3_b : second_v;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_a <= 9'h000; s2_a <= 9'h000; s3_a <= 9'h000;
      s1_b <= 9'h000; s2_b <= 9'h000; s3_b <= 9'h000;
      first_v  <= 9'h000;
      second_v <= 9'h000;
    end
    else
    begin
      s1_a <= sense_first;  s2_a <= s1_a; s3_a <= s2_a;
      s1_b <= sense_second; s2_b <= s1_b; s3_b <= s2_b;
      first_v  <= next_first_v;
      second_v <= next_second_v;
    end
  end

  // Measurement sequencer
  blcr_pkg::blcr_state_type state;
  blcr_pkg::blcr_state_type next_state;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic        next_busy;
  logic        next_reg;
  logic        sel_we;
  logic        res_we;
  logic [8:0]  res_wdata;
  logic [8:0]  sample;

  function automatic logic [8:0] blcr_clamp(input logic [8:0] v);
    // All 9-bit codes fit the 20 mA scale: 511 steps is the full 10.22 A
    blcr_clamp = v;
  endfunction

  assign sel_we = reg_req.wr_en && (reg_req.addr == `BLCR_ADDR_SELECT);

  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    next_busy  = meas_busy;
    next_reg   = meas_regulator;
    res_we     = 1'b0;
    sample     = meas_regulator ? second_v : first_v;
    res_wdata  = blcr_clamp(sample); // see R5
    // A write mid-conversion restarts it on the newly chosen regulator
    if (sel_we)
    begin
      next_state = blcr_pkg::BLCR_CONV; // see R1
      next_cnt   = 16'(CONV_CYCLES - 1);
      next_busy  = 1'b1;
      next_reg   = reg_req.wdata[`BLCR_SEL_BIT]; // see R2
    end
    else
    begin
      case (state)
        blcr_pkg::BLCR_IDLE:
        begin
          next_busy = 1'b0;
        end
        blcr_pkg::BLCR_CONV:
        begin
          if (cnt == 16'h0000)
          begin
            res_we     = 1'b1; // see R7
            next_state = blcr_pkg::BLCR_IDLE;
            next_busy  = 1'b0;
          end
          else
          begin
            next_cnt = cnt - 16'h0001;
          end
        end
        default:
        begin
          next_state = blcr_pkg::BLCR_IDLE;
          next_busy  = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state          <= blcr_pkg::BLCR_IDLE;
      cnt            <= 16'h0000;
      meas_busy      <= 1'b0;
      meas_regulator <= 1'b0;
    end
    else
    begin
      state          <= next_state;
      cnt            <= next_cnt;
      meas_busy      <= next_busy;
      meas_regulator <= next_reg;
    end
  end

  blcr_regs u_regs
  (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .sel_we    (sel_we),
    .sel_wdata (reg_req.wdata),
    .res_we    (res_we),
    .res_wdata (res_wdata),
    .sel_q     (sel_q),
    .res_q     (res_q)
  );

  // Register read path
  logic [7:0] next_rdata;
  logic       next_rvalid;

  always_comb
  begin
    next_rvalid = reg_req.rd_en;
    next_rdata  = 8'h00;
    if (!reg_req.rd_en)
      next_rdata = 8'h00;
    else if (reg_req.addr == `BLCR_ADDR_SELECT)
      next_rdata = sel_q; // see R6
    else if (reg_req.addr == `BLCR_ADDR_HIGH)
      next_rdata = {7'h00, res_q[`BLCR_RESULT_MSB]}; // see R3 see R6
    else if (reg_req.addr == `BLCR_ADDR_LOW)
      next_rdata = res_q[7:0]; // see R4
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rdata  <= next_rdata;
      reg_rvalid <= next_rvalid;
    end
  end

  // Length of each busy run, counted apart from the sequencer so a miscount there shows up
  logic [15:0] busy_len;
  logic [15:0] next_busy_len;

  always_comb
  begin
    next_busy_len = busy_len;
    if (sel_we)
      next_busy_len = 16'h0000;
    else if (meas_busy)
      next_busy_len = busy_len + 16'h0001;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      busy_len <= 16'h0000;
    else
      busy_len <= next_busy_len;
  end

  // Assertions
  start_on_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R1
    sel_we |=> meas_busy && (meas_regulator == $past(reg_req.wdata[0])))
    else $error("write to select did not start measurement");

  high_reserved_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R6
    $past(reg_req.rd_en && reg_req.addr == `BLCR_ADDR_HIGH) |-> reg_rdata[7:1] == 7'h00)
    else $error("high register reserved bits not zero");

  low_readback_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R4
    $past(reg_req.rd_en && reg_req.addr == `BLCR_ADDR_LOW) |-> reg_rdata == $past(res_q[7:0]))
    else $error("low register does not show result bits");

  result_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R7
    !res_we |=> $stable(res_q))
    else $error("result changed without a finished measurement");

  select_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R2
    sel_we |=> sel_q == $past(reg_req.wdata))
    else $error("select register not written");

  conv_length_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R1
    $fell(meas_busy) |-> busy_len == 16'(CONV_CYCLES))
    else $error("measurement length differs from the conversion time");

endmodule
`default_nettype wire

// file: testbench/tb.sv
// Testbench for the load current readout top, driven through its register port.
// Assumes the design files and blcr_cfg.svh are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "blcr_cfg.svh"

module tb;
  // Short conversion keeps the run brief; sense is settled long before each end
  localparam int CONV = 4;
  logic                       ref_clk;
  logic                       arst_n;
  blcr_pkg::blcr_reg_req_type req;
  logic [8:0]                 s_first;
  logic [8:0]                 s_second;
  logic [7:0]                 rdata;
  logic                       rvalid;
  logic                       busy;
  logic                       regsel;
  int                         err_total;
  int                         n_checks;

  blcr_top #(.CONV_CYCLES(CONV)) DUT
  (
    .ref_clk        (ref_clk),
    .arst_n         (arst_n),
    .reg_req        (req),
    .sense_first    (s_first),
    .sense_second   (s_second),
    .reg_rdata      (rdata),
    .reg_rvalid     (rvalid),
    .meas_busy      (busy),
    .meas_regulator (regsel)
  );

  always #25 ref_clk = ~ref_clk;

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    #1;
    req.wr_en = 1'b0;
  endtask

  // Read data stands one cycle, so it is sampled just after the answering edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    #1;
    req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    #1;
    req.rd_en = 1'b0;
    chk({8'h00, rvalid}, 9'h001);
    chk({1'b0, rdata}, {1'b0, exp});
  endtask

  task automatic meas(input logic [7:0] d, input logic [8:0] exp);
    int i;
    wr(`BLCR_ADDR_SELECT, d);
    chk({7'h00, busy, regsel}, {7'h00, 1'b1, d[0]});
    for (i = 0; i < 100 && busy !== 1'b0; i++)
    begin
      @(posedge ref_clk);
      #1;
    end
    chk({8'h00, busy}, 9'h000);
    chk(9'(i), 9'(CONV));
    rd(`BLCR_ADDR_HIGH, {7'h00, exp[8]});
    rd(`BLCR_ADDR_LOW, exp[7:0]);
    rd(`BLCR_ADDR_SELECT, d);
  endtask

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #(50 * 3000);
    err_total++;
    end_sim;
  end

  initial
  begin
    ref_clk = 1'b0;
    arst_n = 1'b0;
    req = '0;
    s_first = 9'h0AA;
    s_second = 9'h1FF;
    err_total = 0;
    n_checks = 0;
    repeat (4) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(`BLCR_ADDR_SELECT, 8'h00);
    rd(`BLCR_ADDR_HIGH, 8'h00);
    rd(`BLCR_ADDR_LOW, 8'h00);
    rd(8'h30, 8'h00);
    $display("test reset_values done");
    // Full scale on the second regulator, then back to the first; reserved bits stay clear
    meas(8'h01, 9'(`BLCR_FULL_SCALE_MA / `BLCR_STEP_MA));
    meas(8'h00, 9'h0AA);
    $display("test select_and_result done");
    wr(`BLCR_ADDR_HIGH, 8'h01);
    wr(`BLCR_ADDR_LOW, 8'h55);
    s_first = 9'h155;
    repeat (10) @(posedge ref_clk);
    rd(`BLCR_ADDR_HIGH, 8'h00);
    rd(`BLCR_ADDR_LOW, 8'hAA);
    $display("test read_only_and_hold done");
    // Same select value written again must still start a fresh measurement
    meas(8'h00, 9'h155);
    s_first = 9'h100;
    s_second = 9'h001;
    repeat (10) @(posedge ref_clk);
    // A second write two cycles into a measurement restarts it on the new choice
    wr(`BLCR_ADDR_SELECT, 8'h01);
    meas(8'h00, 9'h100);
    meas(8'h01, 9'h001);
    $display("test restart_and_both done");
    // Reset in mid-run must drop the select choice and the held result
    @(posedge ref_clk);
    #1;
    arst_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    chk({7'h00, busy, regsel}, 9'h000);
    rd(`BLCR_ADDR_SELECT, 8'h00);
    rd(`BLCR_ADDR_HIGH, 8'h00);
    rd(`BLCR_ADDR_LOW, 8'h00);
    $display("test reset_in_run done");
    end_sim;
  end
endmodule
`default_nettype wire
